/* File: hw/qwd_consts.svh */
// Field positions, reset values and timing counts for the quad wiper decoder
`ifndef QWD_CONSTS_SVH
`define QWD_CONSTS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define QWD_CLK_PERIOD_NS      100
`define QWD_NV_WRITE_TIME_NS   5000000
`define QWD_WIPER_RESP_TIME_NS 1000
// Longest time rounds down
`define QWD_NV_WRITE_CYC  (`QWD_NV_WRITE_TIME_NS / `QWD_CLK_PERIOD_NS)
// Least time rounds up
`define QWD_WIPER_RESP_CYC \
  ((`QWD_WIPER_RESP_TIME_NS + `QWD_CLK_PERIOD_NS - 1) / `QWD_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define QWD_DEVTYPE_MSB 7
`define QWD_DEVTYPE_LSB 4
`define QWD_DEVADDR_MSB 3
`define QWD_TAP_MSB     5
`define QWD_BIT_LAST    3'h7

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define QWD_TAP_MAX     6'h3f
`define QWD_TAP_MIN     6'h00
`define QWD_TAP_RESET   6'h00
`define QWD_NV_RESET    6'h00
`define QWD_PINS_RESET  6'h30
`define QWD_SEL_ZERO    2'h0
`define QWD_MASK_ALL    4'hf
`define QWD_MASK_ONE    4'h1

`endif

/* File: hw/qwd_pkg.sv */
// Types shared by the quad wiper decoder modules
package qwd_pkg;

  typedef logic [5:0]      qwd_tap_t;
  typedef logic [3:0][5:0] qwd_taps_t;

  // Instruction opcodes in the upper nibble of the instruction byte
  typedef enum logic [3:0] {
    OP_GLB_TO_WIPER = 4'h1,
    OP_INCDEC       = 4'h2,
    OP_GLB_TO_NV    = 4'h8,
    OP_RD_WIPER     = 4'h9,
    OP_WR_WIPER     = 4'ha,
    OP_RD_NV        = 4'hb,
    OP_WR_NV        = 4'hc,
    OP_TO_WIPER     = 4'hd,
    OP_TO_NV        = 4'he
  } qwd_op_e;

  // Instruction byte: opcode, pot select, setting select
  typedef struct packed {
    qwd_op_e    op;
    logic [1:0] pot;
    logic [1:0] sel;
  } qwd_instr_s;

  // Pins sampled from outside the clock domain
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic [3:0] addr;
  } qwd_pins_s;

  // One nonvolatile programming job
  typedef struct packed {
    logic [3:0] mask;
    logic [1:0] sel;
    qwd_taps_t  data;
  } qwd_nvreq_s;

  typedef enum logic [8:0] {
    ST_INIT   = 9'h001,
    ST_IDLE   = 9'h002,
    ST_ADDR   = 9'h004,
    ST_INSTR  = 9'h008,
    ST_RX     = 9'h010,
    ST_ACK    = 9'h020,
    ST_TX     = 9'h040,
    ST_MACK   = 9'h080,
    ST_INCDEC = 9'h100
  } qwd_state_e;

endpackage

/* File: hw/qwd_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`include "qwd_consts.svh"

module qwd_sync (
  // Clock and reset
  input  wire logic           core_clk,
  input  wire logic           arst_n,
  input  wire logic           clk_en,
  // Pins in, filtered levels out
  input  wire qwd_pkg::qwd_pins_s din,
  output qwd_pkg::qwd_pins_s  dout
);
  import qwd_pkg::*;

  qwd_pins_s s1_q;
  qwd_pins_s s2_q;
  qwd_pins_s s3_q;

  // Idle bus levels at reset so no false start or stop is seen
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= `QWD_PINS_RESET;
      s2_q <= `QWD_PINS_RESET;
      s3_q <= `QWD_PINS_RESET;
      dout <= `QWD_PINS_RESET;
    end else if (clk_en) begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin // Glitch shorter than a cycle never counts
        dout <= s3_q;
      end
    end
  end

endmodule // qwd_sync

/* File: hw/qwd_nvstore.sv */
// Sixteen stored wiper settings with a timed programming cycle
`timescale 1ns/1ps
`include "qwd_consts.svh"

module qwd_nvstore #(
  parameter int unsigned WRITE_CYCLES = `QWD_NV_WRITE_CYC
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  input  wire logic               clk_en,
  // Programming request
  input  wire logic               go,
  input  wire qwd_pkg::qwd_nvreq_s req,
  output logic                    busy,
  // Read port: one setting of every pot
  input  wire logic [1:0]         rd_sel,
  output qwd_pkg::qwd_taps_t      rd_row
);
  import qwd_pkg::*;

  qwd_tap_t   mem_q [16];
  qwd_nvreq_s req_q;
  logic [31:0] tmr_q;
  logic       done;

  assign done = busy && (tmr_q == 32'(WRITE_CYCLES - 1));

  // ----------------------------------------------------------------
  // Programming timer
  // ----------------------------------------------------------------
  // New value lands only at the end, as a real cell would
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy  <= 1'b0;
      tmr_q <= 32'h0;
      req_q <= '0;
    end else if (clk_en) begin
      if (go) begin
        busy  <= 1'b1;
        tmr_q <= 32'h0;
        req_q <= req;
      end else if (done) begin
        busy  <= 1'b0;
      end else if (busy) begin
        tmr_q <= tmr_q + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Storage, entry index is {pot, setting}
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 16; i++) begin : g_cell
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        mem_q[i] <= `QWD_NV_RESET;
      end else if (clk_en && done && req_q.mask[i / 4] && req_q.sel == 2'(i % 4)) begin
        mem_q[i] <= req_q.data[i / 4];
      end
    end
  end

  // Setting select picks one of four per pot
  for (genvar p = 0; p < 4; p++) begin : g_rd
    assign rd_row[p] = mem_q[{2'(p), rd_sel}];
  end

endmodule // qwd_nvstore

/* File: hw/qwd_decoder.sv */
// Command decoder and wiper registers for a quad wiper on a two-wire bus
`timescale 1ns/1ps
`include "qwd_consts.svh"

// Function
// - Four 6-bit stored settings per pot
// - Stored-setting programming finishes within 5 ms
// - Nine instructions, four take three bytes
// - Opcode 1001 returns selected wiper position
// - Opcode 1010 loads data into wiper
// - Opcode 1011 returns selected stored setting
// - Opcode 1100 programs selected stored setting
// - Opcode 1101 copies setting into wiper
// - Opcode 1110 copies wiper into setting
// - Opcode 0001 loads all wipers from settings
// - Opcode 1000 saves all wipers to settings
// - Data high during clock pulse steps up
// - Data low during clock pulse steps down
// - Wiper-to-setting copy is a timed nonvolatile write
// - Physical wiper follows after response delay
// - Instruction byte: opcode, pot, setting select
// - Setting select chooses setting zero to three
// - No address acknowledge while programming runs
// - Address is type prefix plus address pins
module qwd_decoder #(
  parameter int unsigned NV_WRITE_CYCLES = `QWD_NV_WRITE_CYC,
  parameter logic [3:0]  DEV_TYPE        = 4'ha // Arbitrary value
) (
  // Clock, reset, enable
  input  wire logic           core_clk,
  input  wire logic           arst_n,
  input  wire logic           clk_en,
  // Two-wire bus pins
  input  wire logic           scl_pin,
  input  wire logic           sda_pin_in,
  output logic                sda_pin_out,
  output logic                sda_pin_oe_n,
  // Hard-wired address pins
  input  wire logic [3:0]     addr_pin,
  // Wiper taps and status
  output qwd_pkg::qwd_taps_t  wiper_tap,
  output logic                nv_busy
);
  import qwd_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  qwd_pins_s  pin_raw;
  qwd_pins_s  pin_f;
  logic       scl_prev_q;
  logic       sda_prev_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_ev;
  logic       stop_ev;

  qwd_state_e st_q;
  qwd_state_e nxt_q;
  logic [2:0] cnt_q;
  logic [7:0] sh_q;
  logic       got8_q;
  logic [7:0] tx_q;
  logic       mack_q;
  qwd_instr_s ins_q;

  qwd_instr_s ib;
  logic       addr_ok;
  logic       instr_ok;
  logic       ack_ok;
  qwd_state_e nxt_d;
  logic       byte_end;
  logic       act_ins;
  logic       act_data;
  logic       act_step;

  qwd_taps_t  wcr_q;
  qwd_taps_t  rd_row;
  logic [1:0] rd_sel;
  qwd_tap_t   rd_val;
  logic [7:0] tx_byte;

  qwd_nvreq_s pend_q;
  logic       pend_v_q;
  logic       nv_go;

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  assign pin_raw = '{scl: scl_pin, sda: sda_pin_in, addr: addr_pin};

  qwd_sync u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .din      (pin_raw),
    .dout     (pin_f)
  );

  // Previous filtered levels for edge finding
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else if (clk_en) begin
      scl_prev_q <= pin_f.scl;
      sda_prev_q <= pin_f.sda;
    end
  end

  // Start and stop need the clock high on both sides of the data edge
  assign scl_rise = pin_f.scl & ~scl_prev_q;
  assign scl_fall = ~pin_f.scl & scl_prev_q;
  assign start_ev = pin_f.scl & scl_prev_q & sda_prev_q & ~pin_f.sda;
  assign stop_ev  = pin_f.scl & scl_prev_q & ~sda_prev_q & pin_f.sda;

  // ----------------------------------------------------------------
  // Byte decode
  // ----------------------------------------------------------------
  assign ib = qwd_instr_s'(sh_q);

  // Busy programming cycle hides the device from polling
  assign addr_ok = (sh_q[`QWD_DEVTYPE_MSB:`QWD_DEVTYPE_LSB] == DEV_TYPE)
                && (sh_q[`QWD_DEVADDR_MSB:0] == pin_f.addr)
                && !nv_busy;

  // Only the nine legal encodings are acknowledged
  always_comb begin
    case (ib.op)
      OP_RD_WIPER,
      OP_WR_WIPER,
      OP_INCDEC:       instr_ok = (ib.sel == `QWD_SEL_ZERO);
      OP_RD_NV,
      OP_WR_NV,
      OP_TO_WIPER,
      OP_TO_NV:        instr_ok = 1'b1;
      OP_GLB_TO_WIPER,
      OP_GLB_TO_NV:    instr_ok = (ib.pot == 2'h0);
      default:         instr_ok = 1'b0;
    endcase
  end

  // Where the bus goes after the acknowledge bit
  always_comb begin
    ack_ok = 1'b1;
    nxt_d  = ST_IDLE;
    case (st_q)
      ST_ADDR: begin
        ack_ok = addr_ok;
        nxt_d  = ST_INSTR;
      end
      ST_INSTR: begin
        ack_ok = instr_ok;
        case (ib.op)
          OP_RD_WIPER,
          OP_RD_NV:    nxt_d = ST_TX;
          OP_WR_WIPER,
          OP_WR_NV:    nxt_d = ST_RX;
          OP_INCDEC:   nxt_d = ST_INCDEC;
          default:     nxt_d = ST_IDLE;
        endcase
      end
      default: begin
        ack_ok = 1'b1;
        nxt_d  = ST_IDLE;
      end
    endcase
  end

  assign byte_end = scl_fall & got8_q;
  assign act_ins  = (st_q == ST_INSTR) & byte_end & instr_ok;
  assign act_data = (st_q == ST_RX) & byte_end;
  // Whole pulse only: the stop's lone clock rise must not step the wiper
  assign act_step = (st_q == ST_INCDEC) & scl_fall;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Reset recall reads setting zero of every pot
  assign rd_sel = (st_q == ST_INIT)  ? `QWD_SEL_ZERO :
                  (st_q == ST_INSTR) ? ib.sel : ins_q.sel;

  assign rd_val  = (ins_q.op == OP_RD_WIPER) ? wcr_q[ins_q.pot]
                                             : rd_row[ins_q.pot];
  assign tx_byte = {2'b00, rd_val};

  // ----------------------------------------------------------------
  // Bus sequencer
  // ----------------------------------------------------------------
  // Start and stop override any bit in flight
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q         <= ST_INIT;
      nxt_q        <= ST_IDLE;
      cnt_q        <= 3'h0;
      sh_q         <= 8'h00;
      got8_q       <= 1'b0;
      tx_q         <= 8'h00;
      mack_q       <= 1'b0;
      ins_q        <= '0;
      sda_pin_oe_n <= 1'b1;
    end else if (clk_en) begin
      if (st_q == ST_INIT) begin
        st_q <= ST_IDLE;
      end else if (start_ev) begin
        st_q         <= ST_ADDR;
        cnt_q        <= 3'h0;
        got8_q       <= 1'b0;
        sda_pin_oe_n <= 1'b1;
      end else if (stop_ev) begin
        st_q         <= ST_IDLE;
        sda_pin_oe_n <= 1'b1;
      end else begin
        case (st_q)
          ST_ADDR,
          ST_INSTR,
          ST_RX: begin
            if (scl_rise) begin
              sh_q   <= {sh_q[6:0], pin_f.sda};
              cnt_q  <= cnt_q + 3'h1;
              got8_q <= (cnt_q == `QWD_BIT_LAST);
            end else if (byte_end) begin
              got8_q <= 1'b0;
              cnt_q  <= 3'h0;
              nxt_q  <= nxt_d;
              if (st_q == ST_INSTR) begin
                ins_q <= ib;
              end
              // Refused bytes get no acknowledge; wait for the next start
              if (ack_ok) begin
                st_q         <= ST_ACK;
                sda_pin_oe_n <= 1'b0;
              end else begin
                st_q <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              st_q  <= nxt_q;
              cnt_q <= 3'h0;
              if (nxt_q == ST_TX) begin
                tx_q         <= {tx_byte[6:0], 1'b0};
                sda_pin_oe_n <= tx_byte[7];
              end else begin
                sda_pin_oe_n <= 1'b1;
              end
            end
          end
          ST_TX: begin
            // Only zeros are driven; ones are left to the pull-up
            if (scl_fall) begin
              if (cnt_q == `QWD_BIT_LAST) begin
                sda_pin_oe_n <= 1'b1;
                st_q         <= ST_MACK;
              end else begin
                sda_pin_oe_n <= tx_q[7];
                tx_q         <= {tx_q[6:0], 1'b0};
                cnt_q        <= cnt_q + 3'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              mack_q <= ~pin_f.sda;
            end else if (scl_fall) begin
              cnt_q <= 3'h0;
              // Acknowledged read repeats the same byte
              if (mack_q) begin
                st_q         <= ST_TX;
                tx_q         <= {tx_byte[6:0], 1'b0};
                sda_pin_oe_n <= tx_byte[7];
              end else begin
                st_q <= ST_IDLE;
              end
            end
          end
          ST_INCDEC,
          ST_IDLE: begin
            sda_pin_oe_n <= 1'b1;
          end
          default: begin
            st_q         <= ST_IDLE;
            sda_pin_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // Open-drain data: the level driven is always low
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_pin_out <= 1'b0;
    end else if (clk_en) begin
      sda_pin_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Wiper position registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wcr_q <= {4{`QWD_TAP_RESET}};
    end else if (clk_en) begin
      if (st_q == ST_INIT) begin
        wcr_q <= rd_row;
      end else if (act_ins && ib.op == OP_TO_WIPER) begin
        wcr_q[ib.pot] <= rd_row[ib.pot];
      end else if (act_ins && ib.op == OP_GLB_TO_WIPER) begin
        wcr_q <= rd_row;
      end else if (act_data && ins_q.op == OP_WR_WIPER) begin
        wcr_q[ins_q.pot] <= sh_q[`QWD_TAP_MSB:0];
      end else if (act_step) begin
        // Ends hold rather than wrap
        if (pin_f.sda && wcr_q[ins_q.pot] != `QWD_TAP_MAX) begin
          wcr_q[ins_q.pot] <= wcr_q[ins_q.pot] + 6'h01;
        end else if (!pin_f.sda && wcr_q[ins_q.pot] != `QWD_TAP_MIN) begin
          wcr_q[ins_q.pot] <= wcr_q[ins_q.pot] - 6'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pending nonvolatile job, launched by the stop condition
  // ----------------------------------------------------------------
  // Data is captured when the command is accepted, not at the stop
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q   <= '0;
      pend_v_q <= 1'b0;
    end else if (clk_en) begin
      if (nv_go) begin
        pend_v_q <= 1'b0;
      end else if (act_ins && ib.op == OP_TO_NV) begin
        pend_q   <= '{mask: `QWD_MASK_ONE << ib.pot, sel: ib.sel,
                      data: {4{wcr_q[ib.pot]}}};
        pend_v_q <= 1'b1;
      end else if (act_ins && ib.op == OP_GLB_TO_NV) begin
        pend_q   <= '{mask: `QWD_MASK_ALL, sel: ib.sel, data: wcr_q};
        pend_v_q <= 1'b1;
      end else if (act_data && ins_q.op == OP_WR_NV) begin
        pend_q   <= '{mask: `QWD_MASK_ONE << ins_q.pot, sel: ins_q.sel,
                      data: {4{sh_q[`QWD_TAP_MSB:0]}}};
        pend_v_q <= 1'b1;
      end
    end
  end

  assign nv_go = stop_ev & pend_v_q & (st_q != ST_INIT);

  qwd_nvstore #(
    .WRITE_CYCLES (NV_WRITE_CYCLES)
  ) u_nv (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .go       (nv_go),
    .req      (pend_q),
    .busy     (nv_busy),
    .rd_sel   (rd_sel),
    .rd_row   (rd_row)
  );

  // ----------------------------------------------------------------
  // Wiper response delay, one timer per pot
  // ----------------------------------------------------------------
  // A new position restarts the wait so only a settled value moves the tap
  for (genvar p = 0; p < 4; p++) begin : g_wiper
    qwd_tap_t   last_q;
    logic [7:0] dly_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        last_q       <= `QWD_TAP_RESET;
        dly_q        <= 8'h00;
        wiper_tap[p] <= `QWD_TAP_RESET;
      end else if (clk_en) begin
        last_q <= wcr_q[p];
        if (wcr_q[p] != last_q || wcr_q[p] == wiper_tap[p]) begin
          dly_q <= 8'h00;
        end else if (dly_q == 8'(`QWD_WIPER_RESP_CYC - 1)) begin
          wiper_tap[p] <= wcr_q[p];
          dly_q        <= 8'h00;
        end else begin
          dly_q <= dly_q + 8'h01;
        end
      end
    end
  end

endmodule // qwd_decoder

/* File: verification/qwd_decoder_monitor.sv */
// Concurrent checks on the quad wiper decoder pins
`timescale 1ns/1ps
module qwd_decoder_monitor #(
  parameter int unsigned NV_WRITE_CYCLES = 50000
) (
  // Clock and reset
  input wire logic               core_clk,
  input wire logic               arst_n,
  input wire logic               clk_en,
  // Bus and address pins
  input wire logic               scl_pin,
  input wire logic               sda_pin_in,
  input wire logic               sda_pin_out,
  input wire logic               sda_pin_oe_n,
  input wire logic [3:0]         addr_pin,
  // Taps and status
  input wire qwd_pkg::qwd_taps_t wiper_tap,
  input wire logic               nv_busy
);
  import qwd_pkg::*;
  logic [19:0] busy_cnt_q;
  // ----------------------------------------------------------------
  // Busy length counter
  // ----------------------------------------------------------------
  // A stuck busy flag shows as a count past the job length
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) busy_cnt_q <= '0;
    else if (nv_busy) busy_cnt_q <= busy_cnt_q + 20'h1;
    else busy_cnt_q <= '0;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  out_low_a: assert property (sda_pin_out == 1'b0)
    else $error("data output not low");
  rst_vals_a: assert property ($rose(arst_n) |-> sda_pin_oe_n && !nv_busy)
    else $error("bad state after reset");
  post_rst_a: assert property ($rose(arst_n) |-> (wiper_tap == '0) [*8])
    else $error("wiper not setting zero after reset");
  busy_len_a: assert property ($fell(nv_busy) |-> busy_cnt_q == 20'(NV_WRITE_CYCLES))
    else $error("programming length wrong");
  busy_cap_a: assert property (busy_cnt_q <= 20'(NV_WRITE_CYCLES))
    else $error("programming too long");
  no_ack_busy_a: assert property (nv_busy |-> sda_pin_oe_n)
    else $error("line driven while programming");
  busy_stop_a: assert property ($rose(nv_busy) |-> scl_pin && sda_pin_in)
    else $error("programming began outside stop");
  tap_hold_a: assert property (nv_busy |-> $stable(wiper_tap))
    else $error("tap moved during programming");
  oe_chg_a: assert property ($changed(sda_pin_oe_n) |-> !$past(scl_pin, 3))
    else $error("data line changed in clock high");
  // Main scenarios
  cover property ($rose(nv_busy));
  cover property ($fell(sda_pin_oe_n));
  cover property ($changed(wiper_tap));
endmodule // qwd_decoder_monitor

/* File: verification/qwd_bus_master.sv */
// Two-wire bus master model for the decoder bench
`timescale 1ns/1ps
module qwd_bus_master (
  // Timing reference
  input  wire logic core_clk,
  // Bus lines; sda_o high means released
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_o
);
  // Idle bus: clock stands still high between frames
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  // Quarter of an 800 ns bit, moved on falling edges
  task automatic q;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic start;
    sda_o = 1'b1;
    scl = 1'b1;
    q();
    sda_o = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop;
    sda_o = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_o = 1'b1;
    q();
    q();
  endtask
  // Data changes only while the clock is low; long low half covers filter lag
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    q();
    scl = 1'b1;
    q();
    r = sda_line;
    scl = 1'b0;
    q();
    q();
  endtask
  // Byte MSB first, then ninth clock carrying last
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
                      output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      r[i] = b;
    end
    bit_io(last, b);
    ack = !b;
  endtask
endmodule // qwd_bus_master

/* File: verification/tb_top.sv */
// Self-checking bench for the quad wiper decoder
`timescale 1ns/1ps
module tb_top;
  import qwd_pkg::*;
  localparam int unsigned NVC   = 200;
  localparam logic [3:0]  DEV_T = 4'h6; // Arbitrary value
  logic       core_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic       clk_en = 1'b1;
  logic [3:0] addr_pin = 4'h0;
  logic       scl, sda_m, sda_line, sda_out, sda_oe_n, nv_busy;
  qwd_taps_t  wiper_tap;
  logic [5:0] wip [4];
  logic [5:0] nv [4][4];
  int         seed = 32'h8dc7535f;
  int         errors = 0;
  int         n_compared = 0;
  // Open-drain wire with pull-up
  assign sda_line = sda_m & (sda_oe_n | sda_out);
  always #50 core_clk = ~core_clk;
  qwd_bus_master m (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_o(sda_m));
  qwd_decoder #(.NV_WRITE_CYCLES(NVC), .DEV_TYPE(DEV_T)) uut (
    .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .scl_pin(scl),
    .sda_pin_in(sda_line), .sda_pin_out(sda_out), .sda_pin_oe_n(sda_oe_n),
    .addr_pin(addr_pin), .wiper_tap(wiper_tap), .nv_busy(nv_busy));
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask
  function automatic logic [5:0] step(input logic [5:0] v, input logic up);
    if (up) return (v == 6'h3f) ? v : v + 6'h01;
    return (v == 6'h00) ? v : v - 6'h01;
  endfunction
  // Start, address and instruction; ok when both acknowledged
  task automatic head(input logic [7:0] ins, input logic [3:0] ad, output logic ok);
    logic [7:0] r;
    logic a1, a2;
    m.start();
    m.xfer({DEV_T, ad}, 1'b1, r, a1);
    m.xfer(ins, 1'b1, r, a2);
    ok = a1 & a2;
  endtask
  // Whole command; inc/dec leaves the frame open for pulses
  task automatic cmd(input qwd_op_e op, input logic [1:0] p, s, input logic [7:0] d,
                     input logic ea, output logic [7:0] r);
    logic ok, a;
    a = 1'b1;
    head({op, p, s}, addr_pin, ok);
    if (op inside {OP_RD_WIPER, OP_WR_WIPER, OP_RD_NV, OP_WR_NV}) m.xfer(d, 1'b1, r, a);
    if (op inside {OP_WR_WIPER, OP_WR_NV}) ok = ok & a;
    if (op != OP_INCDEC) m.stop();
    chk("ack", {7'h0, ea}, {7'h0, ok});
  endtask
  // Programming cycle, optionally polled while it runs
  task automatic wait_nv(input logic poll);
    int k;
    logic ok;
    k = 0;
    while (nv_busy !== 1'b1 && k < 50) begin
      @(negedge core_clk);
      k++;
    end
    chk("busy rise", 8'h01, {7'h0, nv_busy});
    if (poll) begin
      head(8'h00, addr_pin, ok);
      m.stop();
      chk("poll ack", 8'h00, {7'h0, ok});
    end
    k = 0;
    while (nv_busy !== 1'b0 && k < NVC + 50) begin
      @(negedge core_clk);
      k++;
    end
    chk("busy fall", 8'h00, {7'h0, nv_busy});
  endtask
  // Taps settle after the response delay
  task automatic chk_taps;
    repeat (20) @(negedge core_clk);
    for (int p = 0; p < 4; p++) chk("tap", {2'b00, wip[p]}, {2'b00, wiper_tap[p]});
  endtask
  initial begin
    #3_000_000;
    errors++;
    end_of_test();
  end
  initial begin
    logic [7:0] r, d;
    int p, s, i;
    addr_pin = 4'($random(seed));
    repeat (20) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (10) @(negedge core_clk);
    for (i = 0; i < 16; i++) begin
      wip[i / 4] = 6'h00;
      nv[i / 4][i % 4] = 6'h00;
    end
    chk_taps();
    for (i = 0; i < 16; i++) begin
      cmd(OP_RD_NV, i[3:2], i[1:0], 8'hff, 1'b1, r);
      chk("setting", {2'b00, nv[i / 4][i % 4]}, r);
    end
    for (p = 0; p < 4; p++) begin
      d = 8'($random(seed));
      cmd(OP_WR_WIPER, p[1:0], 2'h0, d, 1'b1, r);
      wip[p] = d[5:0];
      cmd(OP_RD_WIPER, p[1:0], 2'h0, 8'hff, 1'b1, r);
      chk("wiper", {2'b00, wip[p]}, r);
    end
    chk_taps();
    // Settings used as plain storage, ignored top bits among them
    for (i = 0; i < 6; i++) begin
      p = {$random(seed)} % 4;
      s = i % 4;
      d = (i == 0) ? 8'hff : 8'($random(seed));
      cmd(OP_WR_NV, p[1:0], s[1:0], d, 1'b1, r);
      nv[p][s] = d[5:0];
      wait_nv(i == 0);
      cmd(OP_RD_NV, p[1:0], s[1:0], 8'hff, 1'b1, r);
      chk("setting", {2'b00, nv[p][s]}, r);
    end
    cmd(OP_TO_WIPER, 2'h2, 2'h0, 8'h00, 1'b1, r);
    wip[2] = nv[2][0];
    chk_taps();
    cmd(OP_TO_NV, 2'h3, 2'h1, 8'h00, 1'b1, r);
    nv[3][1] = wip[3];
    wait_nv(1'b0);
    cmd(OP_RD_NV, 2'h3, 2'h1, 8'hff, 1'b1, r);
    chk("copied setting", {2'b00, nv[3][1]}, r);
    cmd(OP_GLB_TO_NV, 2'h0, 2'h2, 8'h00, 1'b1, r);
    for (p = 0; p < 4; p++) nv[p][2] = wip[p];
    wait_nv(1'b0);
    for (p = 0; p < 4; p++) begin
      cmd(OP_RD_NV, p[1:0], 2'h2, 8'hff, 1'b1, r);
      chk("saved setting", {2'b00, nv[p][2]}, r);
    end
    cmd(OP_GLB_TO_WIPER, 2'h0, 2'h0, 8'h00, 1'b1, r);
    for (p = 0; p < 4; p++) wip[p] = nv[p][0];
    chk_taps();
    // Stepping into both ends of the tap range
    cmd(OP_WR_WIPER, 2'h1, 2'h0, 8'h3e, 1'b1, r);
    wip[1] = 6'h3e;
    cmd(OP_INCDEC, 2'h1, 2'h0, 8'h00, 1'b1, r);
    for (i = 0; i < 70; i++) begin
      d[0] = (i < 3) || (i >= 68);
      m.bit_io(d[0], d[1]);
      wip[1] = step(wip[1], d[0]);
      if (i == 2 || i == 67) chk_taps();
    end
    // Frozen enable: this pulse must leave no trace
    clk_en = 1'b0;
    m.bit_io(1'b1, d[1]);
    clk_en = 1'b1;
    m.stop();
    chk_taps();
    // Refused frames leave every wiper untouched
    head({OP_RD_WIPER, 4'h0}, addr_pin ^ 4'h1, d[0]);
    m.stop();
    chk("wrong address ack", 8'h00, {7'h0, d[0]});
    cmd(OP_RD_WIPER, 2'h0, 2'h1, 8'hff, 1'b0, r);
    cmd(qwd_op_e'(4'h3), 2'h0, 2'h0, 8'h00, 1'b0, r);
    cmd(OP_GLB_TO_WIPER, 2'h1, 2'h3, 8'h00, 1'b0, r);
    chk_taps();
    end_of_test();
  end
endmodule // tb_top
bind qwd_decoder qwd_decoder_monitor #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_mon (
  .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .scl_pin(scl_pin),
  .sda_pin_in(sda_pin_in), .sda_pin_out(sda_pin_out), .sda_pin_oe_n(sda_pin_oe_n),
  .addr_pin(addr_pin), .wiper_tap(wiper_tap), .nv_busy(nv_busy));
